// ===== tsq_top.v
// trigger sequencer step delay and loop limits with an apb register slave
`timescale 1ns/1ps
`default_nettype none
`include "tsq_regs.vh"

module tsq_top (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // sequencer state
  output reg o_sequencer_module_enable,
  output reg o_sequence_start,
  output wire o_step_busy,
  output wire o_step_done,
  output wire o_jump_taken,
  output wire o_c0_terminal
);

  // decoding shared by read data and error answer
  function is_mapped;
    input [7:0] addr;
    begin
      case (addr)
        `TSQ_OFF_CTRL: is_mapped = 1'b1;
        `TSQ_OFF_SDLIM: is_mapped = 1'b1;
        `TSQ_OFF_C0LIM: is_mapped = 1'b1;
        `TSQ_OFF_CMD: is_mapped = 1'b1;
        `TSQ_OFF_STATUS: is_mapped = 1'b1;
        `TSQ_OFF_C0VAL: is_mapped = 1'b1;
        `TSQ_OFF_STEPCNT: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // register storage
  reg [15:0] step_delay_limit_q;
  reg [15:0] loop_counter0_limit_q;
  reg [1:0] cmd_code_q;
  reg step_go_q;
  reg jump_seen_q;
  reg [15:0] done_total_q;
  reg [31:0] rd_mux;
  reg [31:0] status_word;

  // bus phases
  wire acc_first;
  wire acc_last;
  wire wr_now;
  wire running;
  wire sd_locked;
  wire c0_locked;

  // submodule state
  wire timer_busy;
  wire timer_done;
  wire [16:0] timer_count;
  wire [15:0] c0_count;
  wire c0_jump;
  wire c0_term;
  wire loop_jump;
  wire loop_incr;
  wire loop_clear;
  wire cmd_accept;

  assign acc_first = i_psel & i_penable & ~o_pready;
  assign acc_last = i_psel & i_penable & o_pready;
  assign wr_now = acc_last & i_pwrite;
  assign running = o_sequencer_module_enable & o_sequence_start;
  assign sd_locked = running;
  assign c0_locked = running;

  // a command is taken only while running and the step timer is idle
  assign cmd_accept = wr_now && (i_paddr == `TSQ_OFF_CMD) && running &&
                      !timer_busy && !step_go_q;

  // command effects on counter 0 fire as the step completes
  assign loop_jump = timer_done && (cmd_code_q == `TSQ_CMD_JMPC0);
  assign loop_incr = timer_done && (cmd_code_q == `TSQ_CMD_C0INC);
  assign loop_clear = timer_done && (cmd_code_q == `TSQ_CMD_C0CLR);

  // one wait state: pready rises on the second access cycle
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= acc_first;
    end
  end

  // read data and error answer are loaded with pready
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_prdata <= `TSQ_RST_DATA;
      o_pslverr <= 1'b0;
    end else if (acc_first) begin
      o_pslverr <= ~is_mapped(i_paddr);
      if (!i_pwrite && is_mapped(i_paddr)) begin
        o_prdata <= rd_mux;
      end else begin
        o_prdata <= `TSQ_RST_DATA;
      end
    end else begin
      o_pslverr <= 1'b0;
    end
  end

  always @* begin
    status_word = `TSQ_RST_DATA;
    status_word[`TSQ_ST_RUN_BIT] = running;
    status_word[`TSQ_ST_BUSY_BIT] = timer_busy | step_go_q;
    status_word[`TSQ_ST_TERM_BIT] = c0_term;
    status_word[`TSQ_ST_JUMP_BIT] = jump_seen_q;
    status_word[`TSQ_ST_CMD_LSB+1:`TSQ_ST_CMD_LSB] = cmd_code_q;
    status_word[`TSQ_ST_DONES_LSB+15:`TSQ_ST_DONES_LSB] = done_total_q;
  end

  always @* begin
    rd_mux = `TSQ_RST_DATA;
    case (i_paddr)
      `TSQ_OFF_CTRL: begin
        rd_mux[`TSQ_CTRL_EN_BIT] = o_sequencer_module_enable;
        rd_mux[`TSQ_CTRL_START_BIT] = o_sequence_start;
      end
      `TSQ_OFF_SDLIM: begin
        rd_mux[15:0] = step_delay_limit_q;
      end
      `TSQ_OFF_C0LIM: begin
        rd_mux[15:0] = loop_counter0_limit_q;
      end
      `TSQ_OFF_CMD: begin
        rd_mux[1:0] = cmd_code_q;
      end
      `TSQ_OFF_STATUS: begin
        rd_mux = status_word;
      end
      `TSQ_OFF_C0VAL: begin
        rd_mux[15:0] = c0_count;
      end
      `TSQ_OFF_STEPCNT: begin
        rd_mux[16:0] = timer_count;
      end
      default: begin
        rd_mux = `TSQ_RST_DATA;
      end
    endcase
  end

  // control bits: start cannot stand without enable
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_sequencer_module_enable <= 1'b0;
      o_sequence_start <= 1'b0;
    end else if (wr_now && i_paddr == `TSQ_OFF_CTRL) begin
      o_sequencer_module_enable <= i_pwdata[`TSQ_CTRL_EN_BIT];
      o_sequence_start <= i_pwdata[`TSQ_CTRL_START_BIT] &
                          i_pwdata[`TSQ_CTRL_EN_BIT];
    end
  end

  // step delay limit
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      step_delay_limit_q <= `TSQ_RST_LIMIT;
    end else if (wr_now && i_paddr == `TSQ_OFF_SDLIM && !sd_locked) begin
      step_delay_limit_q <= i_pwdata[15:0];
    end
  end

  // counter 0 limit
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      loop_counter0_limit_q <= `TSQ_RST_LIMIT;
    end else if (wr_now && i_paddr == `TSQ_OFF_C0LIM && !c0_locked) begin
      loop_counter0_limit_q <= i_pwdata[15:0];
    end
  end

  // command launch into the step timer
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cmd_code_q <= `TSQ_CMD_STEP;
      step_go_q <= 1'b0;
    end else if (cmd_accept) begin
      cmd_code_q <= i_pwdata[1:0];
      step_go_q <= 1'b1;
    end else begin
      step_go_q <= 1'b0;
    end
  end

  // jump flag stays until the next command or until running drops; a jump wins over that clear
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      jump_seen_q <= 1'b0;
    end else if (c0_jump) begin
      jump_seen_q <= 1'b1;
    end else if (cmd_accept || !running) begin
      jump_seen_q <= 1'b0;
    end
  end

  // completed steps, wraps at 16 bits
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      done_total_q <= 16'h0000;
    end else if (timer_done) begin
      done_total_q <= done_total_q + 16'h0001;
    end
  end

  tsq_step_timer u_timer (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_go(step_go_q),
    .i_abort(~running),
    .i_limit(step_delay_limit_q),
    .o_busy(timer_busy),
    .o_done(timer_done),
    .o_count(timer_count)
  );

  tsq_loop_counter u_c0 (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clear(loop_clear),
    .i_jump(loop_jump),
    .i_incr(loop_incr),
    .i_limit(loop_counter0_limit_q),
    .o_count(c0_count),
    .o_jump_taken(c0_jump),
    .o_terminal(c0_term)
  );

  assign o_step_busy = timer_busy;
  assign o_step_done = timer_done;
  assign o_jump_taken = c0_jump;
  assign o_c0_terminal = c0_term;

endmodule
`default_nettype wire

// ===== tsq_regs.vh
// register map, field positions, reset values and commands of the sequencer
`ifndef TSQ_REGS_VH
`define TSQ_REGS_VH

// byte offsets on the register bus
`define TSQ_OFF_CTRL 8'h00
`define TSQ_OFF_SDLIM 8'h04
`define TSQ_OFF_C0LIM 8'h08
`define TSQ_OFF_CMD 8'h0c
`define TSQ_OFF_STATUS 8'h10
`define TSQ_OFF_C0VAL 8'h14
`define TSQ_OFF_STEPCNT 8'h18

// control register fields
`define TSQ_CTRL_EN_BIT 0
`define TSQ_CTRL_START_BIT 1

// status register fields
`define TSQ_ST_RUN_BIT 0
`define TSQ_ST_BUSY_BIT 1
`define TSQ_ST_TERM_BIT 2
`define TSQ_ST_JUMP_BIT 3
`define TSQ_ST_CMD_LSB 4
`define TSQ_ST_DONES_LSB 16

// reset values
`define TSQ_RST_LIMIT 16'h0000
`define TSQ_RST_DATA 32'h0000_0000

// step command codes
`define TSQ_CMD_STEP 2'h0
`define TSQ_CMD_JMPC0 2'h1
`define TSQ_CMD_C0INC 2'h2
`define TSQ_CMD_C0CLR 2'h3

// base delay added to every step, in sequencer clocks
`define TSQ_BASE_DELAY 17'h0_0001

`endif

// ===== tsq_step_timer.v
// step delay timer: one step lasts the limit plus one base clock
`timescale 1ns/1ps
`default_nettype none
`include "tsq_regs.vh"

module tsq_step_timer (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  // control
  input wire i_go,
  input wire i_abort,
  input wire [15:0] i_limit,
  // state
  output reg o_busy,
  output reg o_done,
  output reg [16:0] o_count
);

  wire [16:0] end_count;

  assign end_count = {1'b0, i_limit} + `TSQ_BASE_DELAY;

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_count <= 17'h0_0000;
    end else if (i_abort) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_count <= 17'h0_0000;
    end else if (i_go && !o_busy) begin
      o_busy <= 1'b1;
      o_done <= 1'b0;
      o_count <= 17'h0_0000;
    end else if (o_busy) begin
      if (o_count + 17'h0_0001 == end_count) begin
        o_busy <= 1'b0;
        o_done <= 1'b1;
        o_count <= end_count;
      end else begin
        o_done <= 1'b0;
        o_count <= o_count + 17'h0_0001;
      end
    end else begin
      o_done <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== tsq_loop_counter.v
// counter 0: loop count for jump steps or general purpose limit counter
`timescale 1ns/1ps
`default_nettype none

module tsq_loop_counter (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  // control
  input wire i_clear,
  input wire i_jump,
  input wire i_incr,
  input wire [15:0] i_limit,
  // state
  output reg [15:0] o_count,
  output reg o_jump_taken,
  output reg o_terminal
);

  wire at_limit;

  assign at_limit = (o_count == i_limit);

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_count <= 16'h0000;
      o_jump_taken <= 1'b0;
      o_terminal <= 1'b0;
    end else begin
      o_terminal <= at_limit;
      o_jump_taken <= 1'b0;
      if (i_clear) begin
        o_count <= 16'h0000;
      end else if (i_jump) begin
        // loop again until the count reaches the limit, then fall through
        if (at_limit) begin
          o_count <= 16'h0000;
        end else begin
          o_count <= o_count + 16'h0001;
          o_jump_taken <= 1'b1;
        end
      end else if (i_incr) begin
        // general purpose use: wraps to zero after the limit
        if (at_limit) begin
          o_count <= 16'h0000;
        end else begin
          o_count <= o_count + 16'h0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== tsq_top_sva.sv
// assertions on the register slave and step timing of the sequencer
`timescale 1ns/1ps
`default_nettype none
module tsq_top_sva (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  // apb
  input wire i_psel,
  input wire i_penable,
  input wire o_pready,
  input wire o_pslverr,
  // sequencer state
  input wire o_sequencer_module_enable,
  input wire o_sequence_start,
  input wire o_step_busy,
  input wire o_step_done,
  input wire o_jump_taken
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  sequence run_s;
    o_sequencer_module_enable && o_sequence_start;
  endsequence
  ready_wait_a: assert property (setup_s |-> !o_pready ##2 o_pready)
    else $error("ready not two cycles after setup");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  done_pulse_a: assert property (o_step_done |=> !o_step_done)
    else $error("done longer than one cycle");
  done_idle_a: assert property (o_step_done |-> ##[0:1] !o_step_busy)
    else $error("busy stays after done");
  jump_late_a: assert property (o_jump_taken |-> $past(o_step_done))
    else $error("jump pulse not after done");
  busy_run_a: assert property ($rose(o_step_busy) |-> run_s)
    else $error("step started while not running");
  start_en_a: assert property (o_sequence_start |-> o_sequencer_module_enable)
    else $error("start without enable");
endmodule
bind tsq_top tsq_top_sva tsq_top_sva_inst (
  .i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .o_sequencer_module_enable(o_sequencer_module_enable),
  .o_sequence_start(o_sequence_start),
  .o_step_busy(o_step_busy),
  .o_step_done(o_step_done),
  .o_jump_taken(o_jump_taken)
);
`default_nettype wire

// ===== tb.sv
// self-checking bench for the sequencer limit registers and step commands
`timescale 1ns/1ps
`default_nettype none
`include "tsq_regs.vh"
module tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e, j;
  logic en, st, busy, done, jmp, term;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int n_fail, check_count, cyc;
  tsq_top tsq_top_inst (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_sequencer_module_enable(en),
    .o_sequence_start(st), .o_step_busy(busy), .o_step_done(done),
    .o_jump_taken(jmp), .o_c0_terminal(term));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      results();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      #1;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  // one step command; busy cycles counted up to the done pulse
  task step(input logic [1:0] c, output int nb);
    apb(1'b1, `TSQ_OFF_CMD, {30'h0, c});
    nb = 0;
    do begin
      @(posedge clk);
      #1;
      nb += (busy && !done);
    end while (done !== 1'b1);
    @(posedge clk);
    #1;
    j = jmp;
  endtask
  initial begin
    int l, c, nb;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(71818));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(`TSQ_OFF_SDLIM, 32'h0);
    rd(`TSQ_OFF_C0LIM, 32'h0);
    repeat (4) begin
      l = $urandom;
      apb(1'b1, `TSQ_OFF_SDLIM, l);
      rd(`TSQ_OFF_SDLIM, {16'h0, l[15:0]});
      apb(1'b1, `TSQ_OFF_C0LIM, ~l);
      rd(`TSQ_OFF_C0LIM, {16'h0, ~l[15:0]});
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    $display("test registers done");
    for (int t = 0; t < 3; t++) begin
      l = (t == 0) ? 0 : $urandom_range(6, 1);
      c = t + 1;
      apb(1'b1, `TSQ_OFF_CTRL, 32'h0);
      apb(1'b1, `TSQ_OFF_SDLIM, l);
      apb(1'b1, `TSQ_OFF_C0LIM, c);
      apb(1'b1, `TSQ_OFF_CTRL, 32'h3);
      rd(`TSQ_OFF_CTRL, 32'h3);
      chk({en, st}, 2'b11);
      apb(1'b1, `TSQ_OFF_SDLIM, 32'hffff);
      apb(1'b1, `TSQ_OFF_C0LIM, 32'hffff);
      rd(`TSQ_OFF_SDLIM, l);
      rd(`TSQ_OFF_C0LIM, c);
      step(`TSQ_CMD_C0CLR, nb);
      for (int k = 0; k <= c; k++) begin
        step(`TSQ_CMD_JMPC0, nb);
        chk(nb, l + 1);
        chk(j, k < c);
      end
      for (int k = 1; k <= c; k++) begin
        step(`TSQ_CMD_C0INC, nb);
        @(posedge clk);
        #1;
        chk(term, k == c);
      end
      step(`TSQ_CMD_STEP, nb);
      chk(nb, l + 1);
      $display("test trial %0d done", t);
    end
    results();
  end
endmodule
`default_nettype wire
